//--- bench/switch_core_ur_and_intx_map_tb_top.sv
// Testbench for the switch-core UR classifier and INTx aggregation
`timescale 1ns/1ps
`default_nettype none
module switch_core_ur_and_intx_map_tb_top
  import sw_core_pkg::*;
;
  logic       core_clk_i;
  logic       srst_i;
  logic       hold;
  tlp_hdr_t   tlp;
  tlp_hdr_t   h;
  port_cfg_t  cu;
  port_cfg_t  cb;
  port_cfg_t  cc;
  logic       cpl_rdy;
  logic       err_rdy;
  logic       ix_rdy;
  ur_cpl_t    cpl;
  logic       err;
  logic [4:0] merged;
  logic [2:0] st;
  logic       fwd;
  logic       disc;
  logic       drop;
  logic [3:0] ib;
  logic [3:0] ic;
  logic [3:0] agg;
  intx_msg_t  msg;
  int         err_count;
  int         comparisons;

  // Clock at 40 MHz
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  switch_core_ur dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .tlp_i(tlp), .cfg_up_i(cu), .cfg_b_i(cb), .cfg_c_i(cc),
    .cpl_ready_i(cpl_rdy), .err_ready_i(err_rdy), .cpl_o(cpl),
    .err_msg_o(err), .err_merged_o(merged), .ur_status_o(st),
    .fwd_o(fwd), .discard_o(disc), .cpl_dropped_o(drop),
    .intx_b_i(ib), .intx_c_i(ic), .intx_ready_i(ix_rdy),
    .intx_agg_o(agg), .intx_msg_o(msg));

  ur_partner partner (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .hold_i(hold), .cpl_ready_o(cpl_rdy), .err_ready_o(err_rdy),
    .intx_ready_o(ix_rdy));

  // ********
  // Shared tasks
  // ********
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask : cyc

  function automatic tlp_hdr_t mk(input logic [1:0] s, input tlp_kind_t k,
                                  input logic np);
    mk = '0;
    mk.valid = 1'b1;
    mk.src_port = s;
    mk.kind = k;
    mk.non_posted = np;
    mk.hit_dn_win = (s == PORT_DNB) ? 2'h2 : 2'h1;
    mk.tag_req_id = {14'h1A5C, s};
  endfunction : mk

  // One TLP, judged just after the edge that takes it
  task automatic tc(input tlp_hdr_t t, input logic u);
    tlp = t;
    @(posedge core_clk_i);
    #1;
    chk("fwd", 16'(!u), 16'(fwd));
    chk("discard", 16'(u && !t.non_posted), 16'(disc));
    chk("cpl valid", 16'(u && t.non_posted), 16'(cpl.valid));
    if (u && t.non_posted) begin
      chk("cpl port", 16'(t.src_port), 16'(cpl.port));
      chk("cpl tag", t.tag_req_id, cpl.tag_req_id);
    end
    if (u) chk("status", 16'h1, 16'(st[t.src_port]));
    if (u) chk("err msg", 16'h1, 16'(err));
    #1;
    tlp = '0;
    cyc(3);
    {cu, cb, cc} = {3{8'hF6}};
  endtask : tc

  // Waits for a taken INTx message and judges it
  task automatic wmsg(input logic a, input logic [1:0] ln,
                      input logic [3:0] ag);
    int n;
    n = 0;
    // Look just after each edge, once the core has updated its outputs
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (!(msg.valid === 1'b1 && ix_rdy === 1'b1) && n < 10);
    chk("intx valid", 16'h1, 16'(msg.valid));
    chk("intx kind", 16'(a), 16'(msg.assert_msg));
    chk("intx lane", 16'(ln), 16'(msg.lane));
    chk("intx agg", 16'(ag), 16'(agg));
    #1;
  endtask : wmsg

  // ********
  // Scenarios
  // ********
  task automatic t_up;
    tc(mk(PORT_UP, TLP_MEM, 1'b1), 1'b0);
    tc(mk(PORT_UP, TLP_CFG0, 1'b1), 1'b1);
    h = mk(PORT_UP, TLP_CFG1, 1'b1);
    h.hit_dn_win = 2'h0;
    h.id_route_hit = 1'b1;
    h.id_dest = PORT_DNB;
    h.cfg_dev_num = 5'h01;
    tc(h, 1'b1);
    h.cfg_dev_num = 5'h00;
    tc(h, 1'b0);
    h = mk(PORT_UP, TLP_MEM, 1'b1);
    h.hit_up_win = 1'b1;
    h.hit_dn_win = 2'h0;
    tc(h, 1'b1);
    h = mk(PORT_UP, TLP_MEM, 1'b0);
    h.hit_dn_win = 2'h0;
    h.dest_is_up = 1'b1;
    tc(h, 1'b1);
    h.dest_is_up = 1'b0;
    tc(h, 1'b1);
    h.vga_hit = 1'b1;
    cu.vga_forward_enable = 1'b1;
    tc(h, 1'b1);
  endtask : t_up

  task automatic t_dis;
    h = mk(PORT_UP, TLP_MEM, 1'b1);
    cb.link_up = 1'b0;
    tc(h, 1'b1);
    cu.memory_space_enable = 1'b0;
    tc(h, 1'b1);
    h.kind = TLP_IO;
    cu.io_space_enable = 1'b0;
    tc(h, 1'b1);
    h.kind = TLP_MSG_ADDR;
    h.non_posted = 1'b0;
    {cu.bridge_init, cb.bridge_init, cc.bridge_init} = 3'h0;
    tc(h, 1'b1);
  endtask : t_dis

  task automatic t_dn;
    h = mk(PORT_DNB, TLP_MEM, 1'b1);
    tc(h, 1'b0);
    h.kind = TLP_CFG0;
    tc(h, 1'b1);
    h.kind = TLP_CFG1;
    tc(h, 1'b1);
    h = mk(PORT_DNC, TLP_MSG_ID, 1'b0);
    h.hit_dn_win = 2'h0;
    h.id_route_hit = 1'b1;
    h.id_dest = PORT_DNB;
    tc(h, 1'b0);
    h.id_to_primary = 1'b1;
    tc(h, 1'b1);
    h.id_to_primary = 1'b0;
    cb.pri_eq_sec = 1'b1;
    tc(h, 1'b1);
    tc(mk(PORT_DNB, TLP_MSG_BCAST, 1'b0), 1'b1);
    h = mk(PORT_DNB, TLP_MEM, 1'b1);
    h.vga_hit = 1'b1;
    cc.vga_forward_enable = 1'b1;
    tc(h, 1'b0);
    cb.vga_forward_enable = 1'b1;
    tc(h, 1'b1);
    h.vga_hit = 1'b0;
    h.hit_dn_win = 2'h0;
    h.dest_is_up = 1'b1;
    cu.bus_master_enable = 1'b0;
    tc(h, 1'b1);
  endtask : t_dn

  // Back-to-back URs while the stacks stall
  task automatic t_ovl;
    int n;
    hold = 1'b1;
    cyc(2);
    for (int i = 1; i <= 3; i++) begin
      tlp = mk(PORT_UP, TLP_CFG0, 1'b1);
      @(posedge core_clk_i);
      #1;
      chk("merged", 16'(i), 16'(merged));
      chk("dropped", 16'(i > 1), 16'(drop));
      chk("err held", 16'h1, 16'(err));
      chk("cpl held", 16'h1, 16'(cpl.valid));
      #1;
    end
    tlp = '0;
    hold = 1'b0;
    n = 0;
    while (err !== 1'b0 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("err sent", 16'h0, 16'(err));
    chk("cpl sent", 16'h0, 16'(cpl.valid));
  endtask : t_ovl

  task automatic t_intx;
    logic [1:0] r;
    for (int l = 0; l < 4; l++) begin
      r = 2'(l + 1);
      ib = 4'h1 << l;
      wmsg(1'b1, 2'(l), 4'h1 << l);
      ib = 4'h0;
      wmsg(1'b0, 2'(l), 4'h0);
      ic = 4'h1 << l;
      wmsg(1'b1, r, 4'h1 << r);
      ic = 4'h0;
      wmsg(1'b0, r, 4'h0);
    end
  endtask : t_intx

  task automatic t_down;
    ic = 4'h1;
    wmsg(1'b1, 2'h1, 4'h2);
    cc.link_up = 1'b0;
    wmsg(1'b0, 2'h1, 4'h0);
    ic = 4'h0;
    cc.link_up = 1'b1;
    cyc(4);
  endtask : t_down

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    srst_i = 1'b1;
    hold = 1'b0;
    tlp = '0;
    {cu, cb, cc} = {3{8'hF6}};
    ib = 4'h0;
    ic = 4'h0;
    cyc(10);
    srst_i = 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("reset status", 16'h0, 16'(st));
    chk("reset cpl", 16'h0, 16'(cpl.valid));
    chk("reset err", 16'h0, 16'(err));
    chk("reset agg", 16'h0, 16'(agg));
    #1;
    t_up();
    t_dis();
    t_dn();
    t_ovl();
    t_intx();
    t_down();
    stop_test();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #(25 * 20000);
    err_count++;
    stop_test();
  end
endmodule : switch_core_ur_and_intx_map_tb_top
`default_nettype wire

//--- bench/ur_partner.sv
// Partner model: port stacks taking UR completions, errors and INTx
`timescale 1ns/1ps
`default_nettype none
module ur_partner
  import sw_core_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  // Stall request from the bench
  input  wire logic hold_i,
  // Ready levels toward the core
  output logic      cpl_ready_o,
  output logic      err_ready_o,
  output logic      intx_ready_o
);
  // ********
  // Ready logic
  // ********
  logic rdy_r;
  logic rdy_nxt;

  // Stalls while told to and while in reset, so no port is starved for good
  always_comb begin
    rdy_nxt = ~hold_i & ~srst_i;
  end

  // Ready changes just after an edge, like a real stack
  always_ff @(posedge core_clk_i) begin
    rdy_r <= rdy_nxt;
  end

  assign cpl_ready_o  = rdy_r;
  assign err_ready_o  = rdy_r;
  assign intx_ready_o = rdy_r;
endmodule : ur_partner
`default_nettype wire

//--- src/intx_map.sv
// INTx aggregation of downstream virtual wires onto the upstream port
`timescale 1ns/1ps
`default_nettype none
module intx_map
  import sw_core_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  // Downstream wires and link state
  input  wire logic [NUM_INTX-1:0] intx_b_i,
  input  wire logic [NUM_INTX-1:0] intx_c_i,
  input  wire logic                link_up_b_i,
  input  wire logic                link_up_c_i,
  // Message handshake with upstream stack
  input  wire logic                msg_ready_i,
  output logic [NUM_INTX-1:0]      agg_o,
  output intx_msg_t                msg_o
);

  // ****************************************************************
  // Mapping and link-down gating
  // ****************************************************************
  logic [NUM_INTX-1:0] b_eff;
  logic [NUM_INTX-1:0] c_eff;
  logic [NUM_INTX-1:0] agg_nxt;
  logic [NUM_INTX-1:0] agg_r;
  logic [NUM_INTX-1:0] sent_r;
  logic [NUM_INTX-1:0] sent_nxt;
  intx_msg_t           msg_r;
  intx_msg_t           msg_nxt;

  // Wires of a port in link-down read as deasserted
  always_comb begin
    b_eff = link_up_b_i ? intx_b_i : '0;
    c_eff = link_up_c_i ? intx_c_i : '0;
  end

  // Only the upstream bridge rotates; port B is device 0, C device 1
  for (genvar i = 0; i < NUM_INTX; i++) begin : g_map
    assign agg_nxt[i] = b_eff[i] | c_eff[(i + 3) % 4];
  end

  // ****************************************************************
  // Message generation on edges of the aggregate
  // ****************************************************************
  // Sent state tracks what the root believes; one message per edge
  always_comb begin
    sent_nxt = sent_r;
    msg_nxt  = msg_r;
    if (msg_r.valid && msg_ready_i) begin
      msg_nxt.valid = 1'b0;
    end
    if (!msg_nxt.valid) begin
      for (int j = NUM_INTX - 1; j >= 0; j--) begin
        if (agg_r[j] != sent_r[j]) begin
          msg_nxt.valid      = 1'b1;
          msg_nxt.assert_msg = agg_r[j];
          msg_nxt.lane       = 2'(j);
        end
      end
      if (msg_nxt.valid) begin
        sent_nxt[msg_nxt.lane] = msg_nxt.assert_msg;
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      agg_r  <= '0;
      sent_r <= '0;
      msg_r  <= '0;
    end else begin
      agg_r  <= agg_nxt;
      sent_r <= sent_nxt;
      msg_r  <= msg_nxt;
    end
  end

  assign agg_o = agg_r;
  assign msg_o = msg_r;

  // Assert on the very edge only when the root saw it negated
  property p_intx_edge;
    @(posedge core_clk_i) disable iff (srst_i)
      (msg_r.valid && msg_ready_i) |-> sent_r[msg_r.lane] == msg_r.assert_msg;
  endproperty
  a_intx_edge: assert property (p_intx_edge)
    else $error("INTx message does not match tracked state");

  property p_link_down;
    @(posedge core_clk_i) disable iff (srst_i)
      !link_up_c_i |=> agg_r == $past(b_eff);
  endproperty
  a_link_down: assert property (p_link_down)
    else $error("Aggregate holds wires of a link-down port");

  property p_map_a;
    @(posedge core_clk_i) disable iff (srst_i)
      (link_up_b_i && link_up_c_i) |=>
        agg_r[0] == ($past(intx_b_i[0]) | $past(intx_c_i[3]));
  endproperty
  a_map_a: assert property (p_map_a)
    else $error("Upstream INTA mapping wrong");

endmodule : intx_map
`default_nettype wire

//--- src/sw_core_pkg.sv
// Package: constants and carrier types for the switch-core UR and INTx logic
package sw_core_pkg;

  // ****************************************************************
  // Port indices and INTx lanes
  // ****************************************************************
  localparam int unsigned NUM_INTX  = 4;
  localparam logic [1:0]  PORT_UP   = 2'h0;
  localparam logic [1:0]  PORT_DNB  = 2'h1;
  localparam logic [1:0]  PORT_DNC  = 2'h2;
  localparam logic [1:0]  PORT_NONE = 2'h3;

  // ****************************************************************
  // Pending UR completion slots and error-message collapse
  // ****************************************************************
  localparam int unsigned CPL_SLOTS   = 1;
  localparam logic [4:0]  ERR_CNT_MAX = 5'h1F;

  // Kinds of TLP as seen by the core
  typedef enum logic [2:0] {
    TLP_MEM = 3'h0,
    TLP_IO  = 3'h1,
    TLP_CFG0 = 3'h2,
    TLP_CFG1 = 3'h3,
    TLP_MSG_ADDR = 3'h4,
    TLP_MSG_ID   = 3'h5,
    TLP_MSG_BCAST = 3'h6,
    TLP_CPL  = 3'h7
  } tlp_kind_t;

  // Decoded header of an incoming TLP, with routing results from the
  // address and ID decoders of the port bridges
  typedef struct packed {
    logic       valid;
    logic [1:0] src_port;
    tlp_kind_t  kind;
    logic       non_posted;
    logic       hit_up_win;     // Address hits upstream memory or I/O window
    logic [1:0] hit_dn_win;     // Address hits port B / port C window
    logic       id_route_hit;   // ID routed to some port
    logic [1:0] id_dest;        // Port selected by ID route
    logic       id_to_primary;  // ID equals bridge primary bus number
    logic       dest_is_up;     // Address-routed destination is upstream
    logic [4:0] cfg_dev_num;    // Device number of a type 1 converted
    logic       vga_hit;        // TLP falls in the VGA region
    logic [15:0] tag_req_id;    // Requester tag and ID, echoed in completion
  } tlp_hdr_t;

  // Per-port bridge configuration state
  typedef struct packed {
    logic link_up;
    logic memory_space_enable;
    logic io_space_enable;
    logic bus_master_enable;
    logic vga_forward_enable;
    logic bridge_init;          // Bridge configured by software
    logic bus_enumerated;
    logic pri_eq_sec;           // Primary bus number equals secondary
  } port_cfg_t;

  // UR completion request to a port stack
  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
    logic [15:0] tag_req_id;
  } ur_cpl_t;

  // INTx virtual-wire message to the upstream stack
  typedef struct packed {
    logic       valid;
    logic       assert_msg;     // 1 Assert_INTx, 0 Deassert_INTx
    logic [1:0] lane;           // 0=A .. 3=D
  } intx_msg_t;

endpackage : sw_core_pkg

//--- src/switch_core_ur.sv
// Switch core: UR classification, UR completions, error messages, INTx
`timescale 1ns/1ps
`default_nettype none
module switch_core_ur
  import sw_core_pkg::*;
(
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  // Incoming decoded TLP
  input  wire tlp_hdr_t            tlp_i,
  // Bridge state of port A (up), B and C
  input  wire port_cfg_t           cfg_up_i,
  input  wire port_cfg_t           cfg_b_i,
  input  wire port_cfg_t           cfg_c_i,
  // UR completion and error message handshakes
  input  wire logic                cpl_ready_i,
  input  wire logic                err_ready_i,
  output ur_cpl_t                  cpl_o,
  output logic                     err_msg_o,
  output logic [4:0]               err_merged_o,
  // Status per port: sticky UR detected, forward decision
  output logic [2:0]               ur_status_o,
  output logic                     fwd_o,
  output logic                     discard_o,
  output logic                     cpl_dropped_o,
  // INTx
  input  wire logic [NUM_INTX-1:0] intx_b_i,
  input  wire logic [NUM_INTX-1:0] intx_c_i,
  input  wire logic                intx_ready_i,
  output logic [NUM_INTX-1:0]      intx_agg_o,
  output intx_msg_t                intx_msg_o
);

  // ****************************************************************
  // Destination resolution
  // ****************************************************************
  logic      from_up;
  logic [1:0] dest;
  logic      dest_valid;
  port_cfg_t dcfg;
  logic      dest_disabled;
  logic      is_ur;

  // Pick destination port from address or ID decoders
  always_comb begin
    from_up    = (tlp_i.src_port == PORT_UP);
    dest       = PORT_NONE;
    dest_valid = 1'b0;
    if (tlp_i.kind == TLP_MSG_ID || tlp_i.kind == TLP_CPL ||
        tlp_i.kind == TLP_CFG1) begin
      dest_valid = tlp_i.id_route_hit;
      dest       = tlp_i.id_dest;
    end else if (tlp_i.hit_dn_win[0]) begin
      dest_valid = 1'b1;
      dest       = PORT_DNB;
    end else if (tlp_i.hit_dn_win[1]) begin
      dest_valid = 1'b1;
      dest       = PORT_DNC;
    end else if (!from_up && tlp_i.dest_is_up) begin
      dest_valid = 1'b1;
      dest       = PORT_UP;
    end
    case (dest)
      PORT_UP:  dcfg = cfg_up_i;
      PORT_DNB: dcfg = cfg_b_i;
      PORT_DNC: dcfg = cfg_c_i;
      default:  dcfg = '0;
    endcase
    // Enables of a downstream port live in the upstream command reg
    dest_disabled = (dest != PORT_UP) && dest_valid &&
                    (!dcfg.link_up ||
                     (tlp_i.kind == TLP_MEM && !cfg_up_i.memory_space_enable) ||
                     (tlp_i.kind == TLP_IO && !cfg_up_i.io_space_enable));
  end

  // ****************************************************************
  // UR classification
  // ****************************************************************
  logic addr_routed;
  logic src_init;

  always_comb begin
    addr_routed = (tlp_i.kind == TLP_MEM) || (tlp_i.kind == TLP_IO) ||
                  (tlp_i.kind == TLP_MSG_ADDR);
    src_init    = (tlp_i.src_port == PORT_UP)  ? cfg_up_i.bridge_init :
                  (tlp_i.src_port == PORT_DNB) ? cfg_b_i.bridge_init :
                                                 cfg_c_i.bridge_init;
    is_ur = 1'b0;
    if (tlp_i.kind == TLP_MSG_ADDR && !src_init)
      is_ur = 1'b1;
    if (addr_routed && tlp_i.hit_up_win && tlp_i.hit_dn_win == 2'h0)
      is_ur = 1'b1;
    if (!dest_valid && tlp_i.kind != TLP_MSG_BCAST && tlp_i.kind != TLP_CFG0)
      is_ur = 1'b1;
    if (dest_disabled)
      is_ur = 1'b1;
    if (from_up) begin
      if (tlp_i.kind == TLP_CFG0)
        is_ur = 1'b1;
      if (tlp_i.kind == TLP_CFG1 && dest != PORT_UP &&
          tlp_i.cfg_dev_num != 5'h00)
        is_ur = 1'b1;
      if (addr_routed && tlp_i.dest_is_up)
        is_ur = 1'b1;
      if (tlp_i.vga_hit && cfg_up_i.vga_forward_enable &&
          !cfg_b_i.vga_forward_enable && !cfg_c_i.vga_forward_enable &&
          tlp_i.hit_dn_win == 2'h0)
        is_ur = 1'b1;
    end else begin
      if (tlp_i.kind == TLP_MSG_ID && tlp_i.id_to_primary &&
          cfg_up_i.bus_enumerated)
        is_ur = 1'b1;
      if (tlp_i.kind == TLP_CFG0 || tlp_i.kind == TLP_CFG1)
        is_ur = 1'b1;
      if (tlp_i.kind == TLP_MSG_ID && dest_valid && dcfg.pri_eq_sec)
        is_ur = 1'b1;
      if (tlp_i.kind == TLP_MSG_BCAST)
        is_ur = 1'b1;
      if (tlp_i.vga_hit &&
          ((tlp_i.src_port == PORT_DNB && cfg_b_i.vga_forward_enable) ||
           (tlp_i.src_port == PORT_DNC && cfg_c_i.vga_forward_enable)))
        is_ur = 1'b1;
      if (dest == PORT_UP && dest_valid && !cfg_up_i.bus_master_enable)
        is_ur = 1'b1;
    end
  end

  // ****************************************************************
  // Completion slot, error collapse and status
  // ****************************************************************
  // One completion slot is shared by all ports; a UR completion that finds it
  // still pending is not queued and falls under the drop path
  ur_cpl_t    cpl_r, cpl_nxt;
  logic       err_r, err_nxt;
  logic [4:0] merged_r, merged_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic       fwd_r, fwd_nxt;
  logic       disc_r, disc_nxt;
  logic       drop_r, drop_nxt;
  logic       ur_ev;

  always_comb begin
    ur_ev      = tlp_i.valid && is_ur;
    cpl_nxt    = cpl_r;
    err_nxt    = err_r;
    merged_nxt = merged_r;
    stat_nxt   = stat_r;
    fwd_nxt    = tlp_i.valid && !is_ur;
    disc_nxt   = ur_ev && !tlp_i.non_posted;
    drop_nxt   = 1'b0;
    if (cpl_r.valid && cpl_ready_i)
      cpl_nxt.valid = 1'b0;
    if (err_r && err_ready_i) begin
      err_nxt    = 1'b0;
      merged_nxt = 5'h00;
    end
    if (ur_ev) begin
      stat_nxt[tlp_i.src_port] = 1'b1;
      err_nxt = 1'b1;
      if (merged_nxt != ERR_CNT_MAX)
        merged_nxt = merged_nxt + 5'h01;
      if (tlp_i.non_posted) begin
        if (!cpl_nxt.valid) begin
          cpl_nxt.valid      = 1'b1;
          cpl_nxt.port       = tlp_i.src_port;
          cpl_nxt.tag_req_id = tlp_i.tag_req_id;
        end else begin
          drop_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cpl_r    <= '0;
      err_r    <= 1'b0;
      merged_r <= 5'h00;
      stat_r   <= 3'h0;
      fwd_r    <= 1'b0;
      disc_r   <= 1'b0;
      drop_r   <= 1'b0;
    end else begin
      cpl_r    <= cpl_nxt;
      err_r    <= err_nxt;
      merged_r <= merged_nxt;
      stat_r   <= stat_nxt;
      fwd_r    <= fwd_nxt;
      disc_r   <= disc_nxt;
      drop_r   <= drop_nxt;
    end
  end

  assign cpl_o         = cpl_r;
  assign err_msg_o     = err_r;
  assign err_merged_o  = merged_r;
  assign ur_status_o   = stat_r;
  assign fwd_o         = fwd_r;
  assign discard_o     = disc_r;
  assign cpl_dropped_o = drop_r;

  // ****************************************************************
  // INTx aggregation
  // ****************************************************************
  intx_map u_intx (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .intx_b_i    (intx_b_i),
    .intx_c_i    (intx_c_i),
    .link_up_b_i (cfg_b_i.link_up),
    .link_up_c_i (cfg_c_i.link_up),
    .msg_ready_i (intx_ready_i),
    .agg_o       (intx_agg_o),
    .msg_o       (intx_msg_o)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_ur_np;
    tlp_i.valid && is_ur && tlp_i.non_posted && !cpl_r.valid;
  endsequence

  property p_err_msg;
    @(posedge core_clk_i) disable iff (srst_i)
      (tlp_i.valid && is_ur) |=> err_r && stat_r[$past(tlp_i.src_port)];
  endproperty
  a_err_msg: assert property (p_err_msg)
    else $error("UR without error message or status");

  property p_err_hold;
    @(posedge core_clk_i) disable iff (srst_i)
      (err_r && !err_ready_i) |=> err_r;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("Error message lost before taken");

  property p_cpl_port;
    @(posedge core_clk_i) disable iff (srst_i)
      s_ur_np |=> cpl_r.valid && cpl_r.port == $past(tlp_i.src_port);
  endproperty
  a_cpl_port: assert property (p_cpl_port)
    else $error("UR completion to wrong port");

  property p_posted;
    @(posedge core_clk_i) disable iff (srst_i)
      (tlp_i.valid && is_ur && !tlp_i.non_posted) |=> discard_o && !fwd_o;
  endproperty
  a_posted: assert property (p_posted)
    else $error("Posted UR not discarded");

  property p_cfg0_up;
    @(posedge core_clk_i) disable iff (srst_i)
      (tlp_i.valid && from_up && tlp_i.kind == TLP_CFG0) |=> !fwd_o;
  endproperty
  a_cfg0_up: assert property (p_cfg0_up)
    else $error("Type 0 config from upstream forwarded");

  property p_dn_cfg;
    @(posedge core_clk_i) disable iff (srst_i)
      (tlp_i.valid && !from_up && tlp_i.kind == TLP_CFG1) |=> !fwd_o;
  endproperty
  a_dn_cfg: assert property (p_dn_cfg)
    else $error("Config from downstream forwarded");

  property p_bcast;
    @(posedge core_clk_i) disable iff (srst_i)
      (tlp_i.valid && !from_up && tlp_i.kind == TLP_MSG_BCAST) |=> !fwd_o;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("Downstream broadcast forwarded");

  property p_bme;
    @(posedge core_clk_i) disable iff (srst_i)
      (tlp_i.valid && !from_up && dest == PORT_UP && dest_valid &&
       !cfg_up_i.bus_master_enable) |=> !fwd_o;
  endproperty
  a_bme: assert property (p_bme)
    else $error("Upstream forward with bus master off");

endmodule : switch_core_ur
`default_nettype wire
